// File: inc/imu_cal_defines.vh
`ifndef IMU_CAL_DEFINES_VH
`define IMU_CAL_DEFINES_VH
// byte addresses of the low byte of each register
`define ADDR_ACCEL_X_LOW 7'h4C
`define ADDR_ACCEL_X_HIGH 7'h4E
`define ADDR_ACCEL_Y_LOW 7'h50
`define ADDR_ACCEL_Y_HIGH 7'h52
`define ADDR_ACCEL_Z_LOW 7'h54
`define ADDR_ACCEL_Z_HIGH 7'h56
`define ADDR_FILTER_SIZE 7'h5C
`define ADDR_RANGE_ID 7'h5E
`define ADDR_MISC_CTRL 7'h60
// reset values
`define RST_OFFSET 16'h0000
`define RST_FILTER_SIZE 16'h0000
`define RST_MISC_CTRL 16'h00C1
// field positions
`define FILT_B_MSB 2
`define MISC_LINEAR_G_BIT 7
`define MISC_PERCUSSION_BIT 6
`define MISC_SYNC_MSB 4
`define MISC_SYNC_LSB 2
`define MISC_SYNC_POL_BIT 1
`define MISC_READY_POL_BIT 0
`define RANGE_FIXED_BITS 2'h3
// sync function codes
`define SYNC_INTERNAL 3'h0
`define SYNC_DIRECT 3'h1
`define SYNC_SCALED 3'h2
`define SYNC_OUTPUT 3'h3
`define SYNC_PULSE 3'h5
// timing: clock rate and internal sample rates
`define CLK_HZ 50000000
`define ACCEL_SAMPLE_HZ 4000
`define ACCEL_TICK_CYCLES (`CLK_HZ / `ACCEL_SAMPLE_HZ)
`define TICK_CNT_W 14
// accumulator width of one averaging stage: 16 bit data plus 8 bits growth
`define ACC_W 24
`endif

// File: rtl/boxcar_stage.v
`timescale 1ns/1ps
`include "imu_cal_defines.vh"
module boxcar_stage
(
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // control
  input wire [2:0] size_i,
  input wire restart_i,
  // data in
  input wire in_valid_i,
  input wire signed [15:0] in_data_i,
  // data out
  output reg out_valid_o,
  output reg signed [15:0] out_data_o
);
  reg signed [15:0] hist [0:127];
  reg [6:0] wr_ptr;
  reg signed [`ACC_W-1:0] acc;
  wire [6:0] taps = 7'h01 << size_i;
  wire [6:0] old_idx = wr_ptr - taps;
  wire signed [15:0] old_val = hist[old_idx];
  wire signed [`ACC_W-1:0] next_acc = acc
    + {{(`ACC_W-16){in_data_i[15]}}, in_data_i}
    - {{(`ACC_W-16){old_val[15]}}, old_val};
  wire signed [`ACC_W-1:0] mean = next_acc >>> size_i;
  integer i;
  // history window, zero filled on restart
  always @(posedge ref_clk_i)
  begin
    if (restart_i)
    begin
      for (i = 0; i < 128; i = i + 1)
        hist[i] <= 16'h0000;
    end
    else if (in_valid_i)
      hist[wr_ptr] <= in_data_i;
  end
  // running sum over the last 2^B samples
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr <= 7'h00;
      acc <= {`ACC_W{1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= 16'h0000;
    end
    else if (restart_i)
    begin
      wr_ptr <= 7'h00;
      acc <= {`ACC_W{1'b0}};
      out_valid_o <= 1'b0;
    end
    else
    begin
      out_valid_o <= in_valid_i;
      if (in_valid_i)
      begin
        wr_ptr <= wr_ptr + 7'h01;
        acc <= next_acc;
        out_data_o <= mean[15:0];
      end
    end
  end
endmodule

// File: rtl/imu_user_calibration_control_regs.v
// Overview of operation
// (RULE1) x offset low/high words form 32-bit correction
// (RULE2) y and z offset pairs act like x
// (RULE3) filter size field bits 2:0, N=2^B
// (RULE4) two cascaded averaging stages, triangular response
// (RULE5) range id: range in 3:2, 1:0 read 11
// (RULE6) bit 7 enables linear-g gyro compensation
// (RULE7) bit 6 enables reference point alignment
// (RULE8) host writes zero to bit 5
// (RULE9) bits 4:2 select sync function
// (RULE10) host never writes reserved sync codes
// (RULE11) bit 1 selects sync edge polarity
// (RULE12) bit 0 sets ready pin polarity
// (RULE13) misc control resets to 0x00C1
// (RULE14) internal mode runs 2000 Hz processing
// (RULE15) accel sampled 4000 Hz, two averaged
// (RULE16) host writes 16-bit register byte by byte
// (RULE17) user offsets follow factory correction stage
// (RULE18) offsets two's complement, next sample uses them
// (RULE19) writes to range id are ignored
`timescale 1ns/1ps
`include "imu_cal_defines.vh"
module imu_user_calibration_control_regs
(
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // byte register port from the serial front end
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [6:0] addr_i,
  input wire [7:0] wr_data_i,
  output reg [15:0] rd_data_o,
  output reg rd_valid_o,
  // strap and sync pin
  input wire [1:0] gyro_range_i,
  input wire sync_i,
  // factory corrected accelerometer samples, one per raw sample
  input wire raw_valid_i,
  input wire signed [15:0] accel_x_i,
  input wire signed [15:0] accel_y_i,
  input wire signed [15:0] accel_z_i,
  // processed outputs
  output reg signed [31:0] accel_x_o,
  output reg signed [31:0] accel_y_o,
  output reg signed [31:0] accel_z_o,
  output reg signed [15:0] filt_x_o,
  output reg sample_tick_o,
  output reg accel_tick_o,
  output reg sync_out_o,
  output reg sync_out_en_o,
  output reg output_valid_indicator_pin_o,
  // option controls to the calibration pipeline
  output reg linear_g_comp_en_o,
  output reg percussion_align_en_o
);
  reg [15:0] accel_x_offset_low_word;
  reg [15:0] accel_x_offset_high_word;
  reg [15:0] accel_y_offset_low_word;
  reg [15:0] accel_y_offset_high_word;
  reg [15:0] accel_z_offset_low_word;
  reg [15:0] accel_z_offset_high_word;
  reg [15:0] smoothing_filter_size;
  reg [15:0] misc_options_control;
  reg [1:0] range_strap;
  reg [`TICK_CNT_W-1:0] tick_cnt;
  reg phase;
  reg sync_d;
  reg signed [15:0] pair_y, pair_z;
  reg signed [15:0] pair_first;
  reg pair_have;
  reg mean_valid;
  reg signed [15:0] mean_x;
  reg signed [15:0] mean_y;
  reg signed [15:0] mean_z;
  reg [2:0] filt_size_d;
  wire [2:0] sync_mode = misc_options_control[`MISC_SYNC_MSB:`MISC_SYNC_LSB];
  wire sync_pol = misc_options_control[`MISC_SYNC_POL_BIT];
  wire ready_pol = misc_options_control[`MISC_READY_POL_BIT];
  wire [6:0] reg_base = {addr_i[6:1], 1'b0};
  wire hi_byte = addr_i[0];
  wire sync_edge = sync_pol ? (sync_i & ~sync_d) : (~sync_i & sync_d);
  wire internal_clk = (sync_mode == `SYNC_INTERNAL) |
    (sync_mode == `SYNC_OUTPUT);
  wire accel_strobe = internal_clk ? (tick_cnt == 0) :
    (sync_mode == `SYNC_DIRECT) ? (sync_i != sync_d) : sync_edge;
  wire [15:0] range_word = {12'h000, range_strap, `RANGE_FIXED_BITS};
  wire stage1_valid;
  wire signed [15:0] stage1_data;
  wire stage2_valid;
  wire signed [15:0] stage2_data;
  wire filt_restart = (filt_size_d != smoothing_filter_size[2:0]);
  wire signed [16:0] pair_sum = {pair_first[15], pair_first} +
    {accel_x_i[15], accel_x_i};
  wire signed [16:0] sum_y = {pair_y[15], pair_y} + {accel_y_i[15], accel_y_i};
  wire signed [16:0] sum_z = {pair_z[15], pair_z} + {accel_z_i[15], accel_z_i};
  wire [15:0] corr_x_low = mean_x + accel_x_offset_low_word; // filter input
  // byte write into one half of a register
  function [15:0] put_byte;
    input [15:0] old;
    input hi;
    input [7:0] b;
    begin
      put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
    end
  endfunction
  // register writes, byte addressed, range id not writable
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      accel_x_offset_low_word <= `RST_OFFSET;
      accel_x_offset_high_word <= `RST_OFFSET;
      accel_y_offset_low_word <= `RST_OFFSET;
      accel_y_offset_high_word <= `RST_OFFSET;
      accel_z_offset_low_word <= `RST_OFFSET;
      accel_z_offset_high_word <= `RST_OFFSET;
      smoothing_filter_size <= `RST_FILTER_SIZE;
      misc_options_control <= `RST_MISC_CTRL; // RULE13
    end
    else if (wr_en_i)
    begin
      case (reg_base) // RULE16
        `ADDR_ACCEL_X_LOW: accel_x_offset_low_word <=
          put_byte(accel_x_offset_low_word, hi_byte, wr_data_i); // RULE1
        `ADDR_ACCEL_X_HIGH: accel_x_offset_high_word <=
          put_byte(accel_x_offset_high_word, hi_byte, wr_data_i); // RULE1
        `ADDR_ACCEL_Y_LOW: accel_y_offset_low_word <=
          put_byte(accel_y_offset_low_word, hi_byte, wr_data_i); // RULE2
        `ADDR_ACCEL_Y_HIGH: accel_y_offset_high_word <=
          put_byte(accel_y_offset_high_word, hi_byte, wr_data_i); // RULE2
        `ADDR_ACCEL_Z_LOW: accel_z_offset_low_word <=
          put_byte(accel_z_offset_low_word, hi_byte, wr_data_i); // RULE2
        `ADDR_ACCEL_Z_HIGH: accel_z_offset_high_word <=
          put_byte(accel_z_offset_high_word, hi_byte, wr_data_i); // RULE2
        `ADDR_FILTER_SIZE: smoothing_filter_size <=
          put_byte(smoothing_filter_size, hi_byte, wr_data_i) &
          16'h0007; // RULE3
        `ADDR_MISC_CTRL: misc_options_control <=
          put_byte(misc_options_control, hi_byte, wr_data_i) &
          16'h00DF; // RULE8
        default: ; // RULE19
      endcase
    end
  end
  // register reads, one cycle after the strobe
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
    end
    else
    begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i)
      begin
        case (reg_base)
          `ADDR_ACCEL_X_LOW: rd_data_o <= accel_x_offset_low_word;
          `ADDR_ACCEL_X_HIGH: rd_data_o <= accel_x_offset_high_word;
          `ADDR_ACCEL_Y_LOW: rd_data_o <= accel_y_offset_low_word;
          `ADDR_ACCEL_Y_HIGH: rd_data_o <= accel_y_offset_high_word;
          `ADDR_ACCEL_Z_LOW: rd_data_o <= accel_z_offset_low_word;
          `ADDR_ACCEL_Z_HIGH: rd_data_o <= accel_z_offset_high_word;
          `ADDR_FILTER_SIZE: rd_data_o <= smoothing_filter_size;
          `ADDR_RANGE_ID: rd_data_o <= range_word; // RULE5
          `ADDR_MISC_CTRL: rd_data_o <= misc_options_control;
          default: rd_data_o <= 16'h0000;
        endcase
      end
    end
  end
  // range strap caught on every clock after release
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      range_strap <= 2'h0;
    else
      range_strap <= gyro_range_i; // RULE5
  end
  // internal 4000 Hz tick, sync pin history
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tick_cnt <= `TICK_CNT_W'd0;
      sync_d <= 1'b0;
    end
    else
    begin
      sync_d <= sync_i;
      if (tick_cnt == `ACCEL_TICK_CYCLES - 1)
        tick_cnt <= `TICK_CNT_W'd0; // RULE15
      else
        tick_cnt <= tick_cnt + `TICK_CNT_W'd1;
    end
  end
  // sample strobes: accel every strobe, processing every second (every strobe in pulse mode)
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      phase <= 1'b0;
      accel_tick_o <= 1'b0;
      sample_tick_o <= 1'b0;
      sync_out_o <= 1'b0;
      sync_out_en_o <= 1'b0;
    end
    else
    begin
      // RULE9
      accel_tick_o <= accel_strobe;
      if (sync_mode == `SYNC_PULSE)
        sample_tick_o <= accel_strobe;
      else if (accel_strobe)
        sample_tick_o <= phase; // RULE14
      else
        sample_tick_o <= 1'b0;
      if (accel_strobe && sync_mode != `SYNC_PULSE)
        phase <= ~phase;
      sync_out_en_o <= (sync_mode == `SYNC_OUTPUT);
      if (sync_mode == `SYNC_OUTPUT && accel_strobe && phase)
        sync_out_o <= sync_pol; // RULE11
      else
        sync_out_o <= ~sync_pol;
    end
  end
  // pairwise mean of accel samples, then user offset added
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pair_first <= 16'h0000;
      pair_have <= 1'b0;
      mean_valid <= 1'b0;
      mean_x <= 16'h0000;
      mean_y <= 16'h0000;
      mean_z <= 16'h0000;
      pair_y <= 16'h0000;
      pair_z <= 16'h0000;
    end
    else
    begin
      mean_valid <= 1'b0;
      if (raw_valid_i)
      begin
        pair_have <= ~pair_have;
        pair_first <= accel_x_i;
        pair_y <= accel_y_i;
        pair_z <= accel_z_i;
        if (pair_have)
        begin
          mean_valid <= 1'b1; // RULE15
          mean_x <= pair_sum[16:1];
          mean_y <= sum_y[16:1]; // RULE2
          mean_z <= sum_z[16:1]; // RULE17
        end
      end
    end
  end
  // offset correction and output indicator
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      accel_x_o <= 32'h00000000;
      accel_y_o <= 32'h00000000;
      accel_z_o <= 32'h00000000;
      output_valid_indicator_pin_o <= 1'b0;
      linear_g_comp_en_o <= 1'b1;
      percussion_align_en_o <= 1'b1;
    end
    else
    begin
      linear_g_comp_en_o <=
        misc_options_control[`MISC_LINEAR_G_BIT]; // RULE6
      percussion_align_en_o <=
        misc_options_control[`MISC_PERCUSSION_BIT]; // RULE7
      if (mean_valid)
      begin
        // RULE18
        accel_x_o <= {{16{mean_x[15]}}, mean_x} +
          {accel_x_offset_high_word, accel_x_offset_low_word}; // RULE1
        accel_y_o <= {{16{mean_y[15]}}, mean_y} +
          {accel_y_offset_high_word, accel_y_offset_low_word}; // RULE2
        accel_z_o <= {{16{mean_z[15]}}, mean_z} +
          {accel_z_offset_high_word, accel_z_offset_low_word}; // RULE2
      end
      output_valid_indicator_pin_o <= mean_valid ? ready_pol :
        ~ready_pol; // RULE12
    end
  end
  // filter size tracked to restart the stages on change
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      filt_size_d <= 3'h0;
      filt_x_o <= 16'h0000;
    end
    else
    begin
      filt_size_d <= smoothing_filter_size[2:0];
      if (stage2_valid)
        filt_x_o <= stage2_data;
    end
  end
  // two cascaded boxcars on corrected x give a triangular window
  boxcar_stage stage_one
  (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .size_i(smoothing_filter_size[`FILT_B_MSB:0]), // RULE3
    .restart_i(filt_restart),
    .in_valid_i(mean_valid),
    .in_data_i(corr_x_low),
    .out_valid_o(stage1_valid),
    .out_data_o(stage1_data)
  );
  boxcar_stage stage_two
  (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .size_i(smoothing_filter_size[`FILT_B_MSB:0]), // RULE4
    .restart_i(filt_restart),
    .in_valid_i(stage1_valid),
    .in_data_i(stage1_data),
    .out_valid_o(stage2_valid),
    .out_data_o(stage2_data)
  );
endmodule

// File: bench/imu_regs_chk.sv
`timescale 1ns/1ps
// option copies, read answers, ready pulse and tick spacing
module imu_regs_chk
(
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // register port
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [6:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire [15:0] rd_data_o,
  input wire rd_valid_o,
  // pins and outputs
  input wire [1:0] gyro_range_i,
  input wire raw_valid_i,
  input wire accel_tick_o,
  input wire sync_out_en_o,
  input wire output_valid_indicator_pin_o,
  input wire linear_g_comp_en_o,
  input wire percussion_align_en_o
);
  logic [7:0] misc;
  logic odd;
  logic armed;
  logic [14:0] gap;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // shadow option byte, sample pairing, tick gap
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      misc <= 8'hC1;
      odd <= 1'b0;
      armed <= 1'b0;
      gap <= 15'h0000;
    end
    else
    begin
      if (wr_en_i && addr_i == 7'h60)
        misc <= wr_data_i & 8'hDF;
      if (raw_valid_i)
        odd <= ~odd;
      gap <= accel_tick_o ? 15'h0000 : gap + 15'h0001;
      if (misc[4:2] != 3'h0)
        armed <= 1'b0;
      else if (accel_tick_o)
        armed <= 1'b1;
    end
  end
  sequence second_raw_s;
    raw_valid_i && odd;
  endsequence
  sequence ready_pulse_s;
    output_valid_indicator_pin_o == misc[0]
      ##1 output_valid_indicator_pin_o != misc[0];
  endsequence
  sequence quiet_s;
    (!raw_valid_i && !wr_en_i)[*5];
  endsequence
  ready_pulse_a: assert property (
    second_raw_s |-> ##[1:3] ready_pulse_s) else $error("no ready pulse");
  ready_idle_a: assert property (
    quiet_s |-> output_valid_indicator_pin_o != misc[0])
    else $error("ready pin not idle");
  lin_g_a: assert property (
    !wr_en_i[*3] |-> linear_g_comp_en_o == misc[7]) else $error("bit 7");
  perc_align_a: assert property (
    !wr_en_i[*3] |-> percussion_align_en_o == misc[6]) else $error("bit 6");
  sync_dir_a: assert property (
    !wr_en_i[*3] |-> sync_out_en_o == (misc[4:2] == 3'h3))
    else $error("sync drive enable");
  misc_read_a: assert property (
    rd_en_i && addr_i[6:1] == 6'h30 |=> rd_valid_o
      && rd_data_o == {8'h00, misc}) else $error("option read");
  range_read_a: assert property (
    rd_en_i && addr_i[6:1] == 6'h2F |=>
      rd_data_o == {12'h000, gyro_range_i, 2'h3}) else $error("range read");
  unmapped_read_a: assert property (
    rd_en_i && addr_i[6:1] == 6'h3F |=> rd_valid_o && rd_data_o == 16'h0000)
    else $error("unmapped read");
  read_pulse_a: assert property (
    !rd_en_i |=> !rd_valid_o) else $error("stray read valid");
  accel_gap_a: assert property (
    accel_tick_o && armed && misc[4:2] == 3'h0 |-> gap == 15'h30D3)
    else $error("accel tick spacing");
endmodule
bind imu_user_calibration_control_regs imu_regs_chk imu_regs_chk_i (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .gyro_range_i(gyro_range_i), .raw_valid_i(raw_valid_i),
  .accel_tick_o(accel_tick_o), .sync_out_en_o(sync_out_en_o),
  .output_valid_indicator_pin_o(output_valid_indicator_pin_o),
  .linear_g_comp_en_o(linear_g_comp_en_o),
  .percussion_align_en_o(percussion_align_en_o));

// File: bench/host_model.sv
`timescale 1ns/1ps
// host side of the byte register port
module host_model
(
  // clock
  input wire ref_clk_i,
  // byte register port
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [6:0] addr_o,
  output logic [7:0] wr_data_o,
  input wire [15:0] rd_data_i,
  input wire rd_valid_i
);
  // idle bus
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 7'h00;
    wr_data_o = 8'h00;
  end
  // word write as two byte writes, low address first
  task write16(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] v;
    begin
      v = d;
      if (a == 7'h60)
        v[5] = 1'b0;
      if (a != 7'h60 || !v[4] || v[3:2] == 2'h1)
      begin
        @(posedge ref_clk_i);
        wr_en_o <= 1'b1;
        addr_o <= {a[6:1], 1'b0};
        wr_data_o <= v[7:0];
        @(posedge ref_clk_i);
        addr_o <= {a[6:1], 1'b1};
        wr_data_o <= v[15:8];
        @(posedge ref_clk_i);
        wr_en_o <= 1'b0;
        addr_o <= ~{a[6:1], 1'b1};
        wr_data_o <= ~v[15:8];
      end
    end
  endtask
  // word read, answer one cycle after the strobe
  task read16(input logic [6:0] a, output logic [15:0] d);
    int n;
    begin
      @(posedge ref_clk_i);
      rd_en_o <= 1'b1;
      addr_o <= a;
      @(posedge ref_clk_i);
      rd_en_o <= 1'b0;
      addr_o <= ~a;
      n = 0;
      do
      begin
        @(posedge ref_clk_i);
        n++;
      end
      while (rd_valid_i !== 1'b1 && n < 4);
      d = rd_valid_i === 1'b1 ? rd_data_i : 16'hXXXX;
    end
  endtask
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic raw_valid_i = 1'b0;
  logic sync_i = 1'b0;
  logic pol = 1'b1;
  logic [1:0] rng = 2'h1;
  logic [15:0] ax = 16'h0000;
  logic [15:0] ay = 16'h0000;
  logic [15:0] az = 16'h0000;
  logic wr_en, rd_en, rd_valid, stick, atick, soen, sout, pin, lin, perc;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [15:0] rdata, filt, d;
  logic [31:0] ox, oy, oz;
  logic [15:0] offs [6] = '{16'h0003, 16'h0001, 16'hFFF0, 16'hFFFF,
    16'h0002, 16'h0000};
  logic [15:0] fexp [3] = '{16'h0040, 16'h00C0, 16'h0100};
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n, i;
  always #10 ref_clk_i = ~ref_clk_i;
  host_model host_model_i (.ref_clk_i(ref_clk_i), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wr_data_o(wdata),
    .rd_data_i(rdata), .rd_valid_i(rd_valid));
  imu_user_calibration_control_regs imu_user_calibration_control_regs_i (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wdata), .rd_data_o(rdata),
    .rd_valid_o(rd_valid), .gyro_range_i(rng), .sync_i(sync_i),
    .raw_valid_i(raw_valid_i), .accel_x_i(ax), .accel_y_i(ay),
    .accel_z_i(az), .accel_x_o(ox), .accel_y_o(oy), .accel_z_o(oz),
    .filt_x_o(filt), .sample_tick_o(stick), .accel_tick_o(atick),
    .sync_out_o(sout), .sync_out_en_o(soen),
    .output_valid_indicator_pin_o(pin), .linear_g_comp_en_o(lin),
    .percussion_align_en_o(perc));
  task finish_test;
    begin
      $display("miscompares %0d samples_checked %0d", miscompares,
        samples_checked);
      if (miscompares == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        miscompares++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rd(input logic [6:0] a, input logic [15:0] e);
    begin
      host_model_i.read16(a, d);
      chk(d, e);
    end
  endtask
  task wr(input logic [6:0] a, input logic [15:0] v);
    host_model_i.write16(a, v);
  endtask
  // one sample pair, then the ready pulse
  task pair(input logic [15:0] x0, x1, y0, y1, z0, z1);
    begin
      @(posedge ref_clk_i);
      raw_valid_i <= 1'b1;
      ax <= x0;
      ay <= y0;
      az <= z0;
      @(posedge ref_clk_i);
      ax <= x1;
      ay <= y1;
      az <= z1;
      @(posedge ref_clk_i);
      raw_valid_i <= 1'b0;
      n = 0;
      while (pin !== pol && n < 8)
      begin
        @(posedge ref_clk_i);
        n++;
      end
      chk(pin, pol);
      @(posedge ref_clk_i);
      chk(pin, !pol);
    end
  endtask
  // move the sync pin, count accel ticks
  task edge_cnt(input logic v, input int e);
    begin
      @(posedge ref_clk_i);
      sync_i <= v;
      n = 0;
      repeat (8)
      begin
        @(posedge ref_clk_i);
        n += atick;
      end
      chk(n, e);
    end
  endtask
  task tick_wait;
    begin
      n = 0;
      do
      begin
        @(posedge ref_clk_i);
        n++;
      end
      while (stick !== 1'b1 && n < 30000);
    end
  endtask
  // hang guard
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      miscompares++;
      finish_test();
    end
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 6; i++)
      rd(7'h4C + 7'(2 * i), 16'h0000);
    rd(7'h5C, 16'h0000);
    rd(7'h60, 16'h00C1);
    rd(7'h5E, {12'h000, rng, 2'h3});
    chk(lin, 1);
    chk(perc, 1);
    tick_wait();
    tick_wait();
    chk(n, 25000);
    for (i = 0; i < 6; i++)
      wr(7'h4C + 7'(2 * i), offs[i]);
    for (i = 0; i < 6; i++)
      rd(7'h4C + 7'(2 * i), offs[i]);
    rd(7'h7E, 16'h0000);
    wr(7'h5E, 16'hFFFF);
    rd(7'h5E, {12'h000, rng, 2'h3});
    rng <= 2'h3;
    rd(7'h5E, 16'h000F);
    pair(16'h0064, 16'h00C8, 16'h000A, 16'h001E, 16'hFFFC, 16'hFFF8);
    chk(ox, 32'h00010099);
    chk(oy, 32'h00000004);
    chk(oz, 32'hFFFFFFFC);
    wr(7'h4E, 16'h0000);
    pair(16'h0064, 16'h00C8, 16'h000A, 16'h001E, 16'hFFFC, 16'hFFF8);
    chk(ox, 32'h00000099);
    wr(7'h5C, 16'hFFFF);
    rd(7'h5C, 16'h0007);
    wr(7'h5C, 16'h0001);
    for (i = 0; i < 3; i++)
    begin
      pair(16'h00FD, 16'h00FD, ay, ay, az, az);
      repeat (8) @(posedge ref_clk_i);
      chk(filt, fexp[i]);
    end
    wr(7'h60, 16'h0041);
    rd(7'h60, 16'h0041);
    chk(lin, 0);
    wr(7'h60, 16'h0081);
    rd(7'h60, 16'h0081);
    chk(perc, 0);
    wr(7'h60, 16'h00E0);
    rd(7'h60, 16'h00C0);
    pol = 1'b0;
    chk(pin, 1);
    pair(ax, ax, ay, ay, az, az);
    pol = 1'b1;
    // output sync mode: pin idles low, pulses high on a processing tick
    wr(7'h60, 16'h00CF);
    repeat (2) @(posedge ref_clk_i);
    chk(sout, 0);
    n = 0;
    while (sout !== 1'b1 && n < 26000)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    chk(sout, 1);
    @(posedge ref_clk_i);
    chk(sout, 0);
    for (i = 0; i < 5; i++)
    begin
      wr(7'h60, {8'h00, 3'h6, modes[i], 2'h3});
      rd(7'h60, {8'h00, 3'h6, modes[i], 2'h3});
      chk(soen, modes[i] == 3'h3);
    end
    wr(7'h60, 16'h00DB);
    rd(7'h60, 16'h00D7);
    wr(7'h60, 16'h00C5);
    edge_cnt(1'b1, 1);
    edge_cnt(1'b0, 1);
    wr(7'h60, 16'h00D7);
    edge_cnt(1'b1, 1);
    edge_cnt(1'b0, 0);
    wr(7'h60, 16'h00D5);
    edge_cnt(1'b1, 0);
    edge_cnt(1'b0, 1);
    finish_test();
  end
endmodule
